/* rtl/adc_params.svh */
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// Register offsets
`define OFS_CONTROL_ZERO 8'h1f
`define OFS_PORT_CONFIG 8'h9f
`define OFS_RESULT 8'h1e
`define OFS_FLAGS 8'h0c

// Control register zero fields
`define BIT_CLK_SEL_HI 7
`define BIT_CLK_SEL_LO 6
`define BIT_CHAN_HI 5
`define BIT_CHAN_LO 3
`define BIT_GO 2
`define BIT_POWER_ON 0

// Flag register fields
`define BIT_DONE_FLAG 0
`define BIT_IRQ_ENABLE 1

// Reset values
`define RST_CONTROL_ZERO 8'h00
`define RST_PORT_CONFIG 3'h0
`define RST_RESULT 8'h00

// Half bit-period lengths in oscillator cycles for codes 00, 01, 10
`define HALF_TAD_OSC2 6'h01
`define HALF_TAD_OSC8 6'h04
`define HALF_TAD_OSC32 6'h10

// Conversion length and post-conversion wait, in half bit periods
`define CONV_HALVES 5'h13
`define WAIT_HALVES 5'h04
`define FIRST_BIT_HALF 5'h02
`define LAST_BIT_HALF 5'h10

// Conversion clock codes
`define CLK_OSC2 2'h0
`define CLK_OSC8 2'h1
`define CLK_OSC32 2'h2
`define CLK_RC 2'h3

`endif

/* rtl/adc_pkg.sv */
package adc_pkg;

  typedef enum logic [1:0] {
    ST_ACQUIRE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_WAIT = 2'b10
  } seq_state_t;

  typedef logic [7:0] byte_t;

endpackage

/* rtl/adc_sequencer_control.sv */
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "adc_params.svh"
// Notes on behaviour
// - Result built bit by bit, MSB first, by successive approximation over 8 bits.
// - Reference is supply or reference-capable pin, chosen by port configuration.
// - Conversion continues during sleep only on the internal RC clock.
// - Clock field 00/01/10 gives 2/8/32 oscillator periods; 11 selects RC clock.
// - Three-bit channel field picks one of eight analog inputs.
// - Writing one to go starts conversion; go reads one while busy.
// - At completion load result, clear go, set the done flag.
// - Converter powered and sequenced only while power-on bit is set.
// - Unimplemented bits read zero and ignore writes.
// - Writable control bits clear to zero at reset.
// - Codes 000-011 decode to analog pins and reference as tabled.
// - Code 100 analog on pins 0,1,3; code 101 analog on pins 0,1; codes 11x all digital.
// - Two bit periods pass after a conversion before acquisition restarts.
// - Clearing go mid-conversion aborts without result update, then waits two periods.
// - Each conversion takes nine and a half bit periods.
module adc_sequencer_control
  import adc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SLEEP,
  input wire logic RC_OSC,
  input wire logic COMP,
  output logic [7:0] DAC_CODE,
  output logic SAMPLE,
  output logic POWER,
  output logic [2:0] CHANNEL,
  output logic REF_EXTERNAL,
  output logic [7:0] PIN_ANALOG,
  output logic DONE_FLAG,
  output logic IRQ_ENABLE
);

  logic rst_meta;
  logic rst_n;
  logic sleep_meta;
  logic sleep_s;
  logic rc_meta;
  logic rc_s;
  logic rc_prev;
  logic comp_meta;
  logic comp_s;
  logic [1:0] clk_sel;
  logic [2:0] chan_sel;
  logic go;
  logic power_on;
  logic [2:0] port_cfg;
  byte_t result;
  byte_t trial;
  byte_t bit_mask;
  logic done_flag;
  logic irq_en;
  seq_state_t state;
  seq_state_t next_state;
  logic [5:0] div_cnt;
  logic [5:0] div_len;
  logic half_tick;
  logic [4:0] half_cnt;
  logic wr_ctl;
  logic wr_cfg;
  logic wr_res;
  logic wr_flg;
  logic go_start;
  logic go_abort;
  logic conv_end;
  logic wait_end;

  function automatic byte_t analog_mask(input logic [2:0] cfg);
    // Bit order: RA0, RA1, RA2, RA3, RA5, RE0, RE1, RE2
    case (cfg)
      3'h0: analog_mask = 8'hff;
      3'h1: analog_mask = 8'hf7;
      3'h2: analog_mask = 8'h1f;
      3'h3: analog_mask = 8'h17;
      3'h4: analog_mask = 8'h0b;
      3'h5: analog_mask = 8'h03;
      default: analog_mask = 8'h00;
    endcase
  endfunction

  function automatic logic ext_reference(input logic [2:0] cfg);
    case (cfg)
      3'h1, 3'h3, 3'h5: ext_reference = 1'b1;
      default: ext_reference = 1'b0;
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Pin synchronisers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sleep_meta <= 1'b0;
      sleep_s <= 1'b0;
      rc_meta <= 1'b0;
      rc_s <= 1'b0;
      rc_prev <= 1'b0;
      comp_meta <= 1'b0;
      comp_s <= 1'b0;
    end else begin
      sleep_meta <= SLEEP;
      sleep_s <= sleep_meta;
      rc_meta <= RC_OSC;
      rc_s <= rc_meta;
      rc_prev <= rc_s;
      comp_meta <= COMP;
      comp_s <= comp_meta;
    end
  end

  // Register decode
  assign wr_ctl = WR && (ADDR == `OFS_CONTROL_ZERO);
  assign wr_cfg = WR && (ADDR == `OFS_PORT_CONFIG);
  assign wr_res = WR && (ADDR == `OFS_RESULT);
  assign wr_flg = WR && (ADDR == `OFS_FLAGS);

  // Go edges from software
  assign go_start = wr_ctl && WDATA[`BIT_GO] && !go && power_on
                    && (state == ST_ACQUIRE);
  assign go_abort = wr_ctl && !WDATA[`BIT_GO] && go;

  // Conversion clock half-period length
  always_comb begin
    case (clk_sel)
      `CLK_OSC2: div_len = `HALF_TAD_OSC2;
      `CLK_OSC8: div_len = `HALF_TAD_OSC8;
      `CLK_OSC32: div_len = `HALF_TAD_OSC32;
      default: div_len = `HALF_TAD_OSC2;
    endcase
  end

  // Oscillator divider halts in sleep; RC edges keep running
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 6'h00;
    end else if (!power_on || state == ST_ACQUIRE || sleep_s) begin
      div_cnt <= 6'h00;
    end else if (div_cnt == div_len - 6'h01) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  always_comb begin
    if (!power_on || state == ST_ACQUIRE) begin
      half_tick = 1'b0;
    end else if (clk_sel == `CLK_RC) begin
      half_tick = rc_s ^ rc_prev;
    end else begin
      half_tick = !sleep_s && (div_cnt == div_len - 6'h01);
    end
  end

  assign conv_end = (state == ST_CONVERT) && half_tick
                    && (half_cnt == `CONV_HALVES - 5'h01);
  assign wait_end = (state == ST_WAIT) && half_tick
                    && (half_cnt == `WAIT_HALVES - 5'h01);

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_ACQUIRE: begin
        if (go_start) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (go_abort || conv_end) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_end) begin
          next_state = ST_ACQUIRE;
        end
      end
      default: next_state = ST_ACQUIRE;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_ACQUIRE;
    end else if (!power_on) begin
      state <= ST_ACQUIRE;
    end else begin
      state <= next_state;
    end
  end

  // Half bit-period counter
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt <= 5'h00;
    end else if (state != next_state || !power_on) begin
      half_cnt <= 5'h00;
    end else if (half_tick) begin
      half_cnt <= half_cnt + 5'h01;
    end
  end

  // Successive approximation
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      trial <= 8'h00;
      bit_mask <= 8'h00;
    end else if (go_start) begin
      trial <= 8'h80;
      bit_mask <= 8'h80;
    end else if (state == ST_CONVERT && half_tick && !half_cnt[0]
                 && half_cnt >= `FIRST_BIT_HALF && half_cnt <= `LAST_BIT_HALF) begin
      trial <= (comp_s ? trial : (trial & ~bit_mask)) | (bit_mask >> 1);
      bit_mask <= bit_mask >> 1;
    end
  end

  // Control register zero
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel <= 2'h0;
      chan_sel <= 3'h0;
      power_on <= 1'b0;
    end else if (wr_ctl) begin
      clk_sel <= WDATA[`BIT_CLK_SEL_HI:`BIT_CLK_SEL_LO];
      chan_sel <= WDATA[`BIT_CHAN_HI:`BIT_CHAN_LO];
      power_on <= WDATA[`BIT_POWER_ON];
    end
  end

  // Go/done status bit
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      go <= 1'b0;
    end else if (!power_on || go_abort || conv_end) begin
      go <= 1'b0;
    end else if (go_start) begin
      go <= 1'b1;
    end
  end

  // Port configuration
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      port_cfg <= `RST_PORT_CONFIG;
    end else if (wr_cfg) begin
      port_cfg <= WDATA[2:0];
    end
  end

  // Result register, kept on abort
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      result <= `RST_RESULT;
    end else if (conv_end) begin
      result <= trial;
    end else if (wr_res) begin
      result <= WDATA;
    end
  end

  // Done flag and enable; completion beats a software clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_flag <= 1'b0;
    end else if (conv_end) begin
      done_flag <= 1'b1;
    end else if (wr_flg) begin
      done_flag <= WDATA[`BIT_DONE_FLAG];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= 1'b0;
    end else if (wr_flg) begin
      irq_en <= WDATA[`BIT_IRQ_ENABLE];
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `OFS_CONTROL_ZERO: RDATA <= {clk_sel, chan_sel, go, 1'b0, power_on};
        `OFS_PORT_CONFIG: RDATA <= {5'h00, port_cfg};
        `OFS_RESULT: RDATA <= result;
        `OFS_FLAGS: RDATA <= {6'h00, irq_en, done_flag};
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Analog side controls
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      DAC_CODE <= 8'h00;
      SAMPLE <= 1'b0;
      POWER <= 1'b0;
      CHANNEL <= 3'h0;
      REF_EXTERNAL <= 1'b0;
      PIN_ANALOG <= 8'h00;
    end else begin
      DAC_CODE <= trial;
      SAMPLE <= power_on && (next_state == ST_ACQUIRE);
      POWER <= power_on;
      CHANNEL <= chan_sel;
      REF_EXTERNAL <= ext_reference(port_cfg);
      PIN_ANALOG <= analog_mask(port_cfg);
    end
  end

  assign DONE_FLAG = done_flag;
  assign IRQ_ENABLE = irq_en;

endmodule // adc_sequencer_control

/* verif/adc_seq_monitor.sv */
`timescale 1ns/1ps
module adc_seq_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic RD,
  input wire logic WR,
  input wire logic [7:0] RDATA,
  input wire logic SAMPLE,
  input wire logic POWER,
  input wire logic [7:0] DAC_CODE,
  input wire logic DONE_FLAG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence conv_start;
    $fell(SAMPLE) && POWER;
  endsequence
  sequence conv_end;
    $rose(DONE_FLAG) && !$past(WR);
  endsequence
  unmapped_read_a: assert property ($past(RD) && !($past(ADDR) inside
    {8'h1f, 8'h9f, 8'h1e, 8'h0c}) |-> RDATA == 8'h00) else $error("unmapped read");
  cfg_unused_a: assert property ($past(RD) && $past(ADDR) == 8'h9f
    |-> RDATA[7:3] == 5'h00) else $error("config high bits");
  ctl_unused_a: assert property ($past(RD) && $past(ADDR) == 8'h1f
    |-> !RDATA[1]) else $error("control bit 1");
  idle_read_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside slot");
  trial_msb_a: assert property (conv_start |-> ##1 DAC_CODE == 8'h80)
    else $error("first trial code");
  early_done_a: assert property (conv_start |-> (!$rose(DONE_FLAG))[*8])
    else $error("conversion too short");
  done_power_a: assert property (conv_end |-> $past(POWER))
    else $error("done while unpowered");
  post_wait_a: assert property (conv_end |-> !SAMPLE[*3])
    else $error("acquisition too soon");
endmodule // adc_seq_monitor
bind adc_sequencer_control adc_seq_monitor u_mon (.CLK(CLK), .RST_N(RST_N),
  .ADDR(ADDR), .RD(RD), .WR(WR), .RDATA(RDATA), .SAMPLE(SAMPLE), .POWER(POWER),
  .DAC_CODE(DAC_CODE), .DONE_FLAG(DONE_FLAG));

/* verif/adc_source_model.sv */
`timescale 1ns/1ps
module adc_source_model (
  input wire logic [63:0] levels,
  input wire logic [2:0] channel,
  input wire logic [7:0] dac_code,
  input wire logic power,
  output logic comp,
  output logic rc_osc
);
  logic [7:0] level;
  initial rc_osc = 1'b0;
  // Free running RC clock
  always #37 rc_osc = ~rc_osc;
  assign level = levels[{channel, 3'h0} +: 8];
  // Unpowered comparator wanders
  assign comp = power ? (level >= dac_code) : rc_osc;
endmodule // adc_source_model

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import adc_pkg::*;
;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic SLEEP = 1'b0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  byte_t ADDR = 8'h00;
  byte_t WDATA = 8'h00;
  byte_t RDATA, DAC_CODE, PIN_ANALOG, d;
  logic [2:0] CHANNEL;
  logic RC_OSC, COMP, SAMPLE, POWER, REF_EXTERNAL, DONE_FLAG, IRQ_ENABLE;
  logic [63:0] levels = 64'h0000_0000_3c00_a700;
  byte_t pin_exp [8] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00, 8'h00};
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int t0, i;
  adc_sequencer_control dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP), .RC_OSC(RC_OSC), .COMP(COMP),
    .DAC_CODE(DAC_CODE), .SAMPLE(SAMPLE), .POWER(POWER), .CHANNEL(CHANNEL),
    .REF_EXTERNAL(REF_EXTERNAL), .PIN_ANALOG(PIN_ANALOG), .DONE_FLAG(DONE_FLAG),
    .IRQ_ENABLE(IRQ_ENABLE));
  adc_source_model model (.levels(levels), .channel(CHANNEL), .dac_code(DAC_CODE),
    .power(POWER), .comp(COMP), .rc_osc(RC_OSC));
  always #5 CLK = ~CLK;
  task automatic test_done;
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input byte_t got, input byte_t exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input byte_t a, input byte_t v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input byte_t a);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
    @(posedge CLK);
  endtask
  task automatic rdc(input byte_t a, input byte_t e);
    rd(a);
    chk(d, e);
  endtask
  task automatic settle;
    while (POWER === 1'b1 && SAMPLE !== 1'b1) @(posedge CLK);
  endtask
  task automatic go(input byte_t c);
    settle();
    wr(8'h1f, c);
    repeat (30) @(posedge CLK);
    wr(8'h0c, 8'h02);
    t0 = cycles;
    wr(8'h1f, c | 8'h04);
  endtask
  task automatic poll;
    rd(8'h1f);
    while (d[2] === 1'b1) rd(8'h1f);
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    rdc(8'h1f, 8'h00);
    rdc(8'h9f, 8'h00);
    rdc(8'h55, 8'h00);
    wr(8'h9f, 8'hff);
    rdc(8'h9f, 8'h07);
    wr(8'h1f, 8'hfe);
    rdc(8'h1f, 8'hf8);
    for (i = 0; i < 8; i++) begin
      wr(8'h9f, 8'(i));
      @(posedge CLK);
      chk(PIN_ANALOG, pin_exp[i]);
      chk({7'h00, REF_EXTERNAL}, 8'((i < 6) ? i % 2 : 0));
    end
    wr(8'h9f, 8'h00);
    for (i = 0; i < 3; i++) begin
      go({i[1:0], 6'h09});
      rdc(8'h1f, {i[1:0], 6'h0d});
      poll();
      chk(8'(cycles - t0 >= 19 << (2 * i) && cycles - t0 < (19 << (2 * i)) + 14), 8'h01);
    end
    rdc(8'h1e, 8'ha7);
    rdc(8'h0c, 8'h03);
    chk({7'h00, DONE_FLAG}, 8'h01);
    chk({7'h00, IRQ_ENABLE}, 8'h01);
    settle();
    SLEEP <= 1'b1;
    go(8'hd9);
    chk({5'h00, CHANNEL}, 8'h03);
    poll();
    rdc(8'h1e, 8'h3c);
    levels[15:8] = 8'h5a;
    go(8'h49);
    repeat (150) @(posedge CLK);
    rdc(8'h1f, 8'h4d);
    SLEEP <= 1'b0;
    poll();
    rdc(8'h1e, 8'h5a);
    levels[15:8] = 8'h81;
    go(8'h49);
    repeat (20) @(posedge CLK);
    wr(8'h1f, 8'h49);
    repeat (30) @(posedge CLK);
    rdc(8'h1e, 8'h5a);
    rdc(8'h0c, 8'h02);
    go(8'h49);
    poll();
    rdc(8'h1e, 8'h81);
    test_done();
  end
endmodule // tb_top
